// *** ldc_pkg.sv ***
// Function
// - SDA falling while SCL high is start.
// - SDA rising while SCL high is stop.
// - Bus busy from start until stop.
// - Repeated start acts like a start.
// - SDA changes only while SCL is low.
// - Answer only to seven-bit address 1010011.
// - Direction bit zero writes, one reads.
// - Write: register address byte, then data.
// - Bytes are eight bits, MSB first.
// - Device pulls SDA low on ninth clock.
// - Low three bits select the operating mode.
// - Enable field mirrored between both brightness registers.
// - Torch bits five to three hold torch level.
// - Torch bits seven, six select indicator current.
// - Enable codes decode; flash codes clear on timeout.
// - Light load gives pulsed converter operation; the code also requires the voltage output enable bit, torch bit two.
// - Config one bit zero disables light load.
package ldc_pkg;

   // Seven-bit slave address of the device.
   localparam logic [6:0] DEV_ADDR = 7'h53;
   // Bits in one byte on the wire.
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Number of control registers.
   localparam int NUM_REGS = 8;

   // Register offsets as seen on the serial port.
   localparam logic [7:0] OFS_GPIO = 8'h20;
   localparam logic [7:0] OFS_VIN = 8'h80;
   localparam logic [7:0] OFS_TORCH = 8'hA0;
   localparam logic [7:0] OFS_FLASH = 8'hB0;
   localparam logic [7:0] OFS_DUR = 8'hC0;
   localparam logic [7:0] OFS_FLAGS = 8'hD0;
   localparam logic [7:0] OFS_CFG1 = 8'hE0;
   localparam logic [7:0] OFS_CFG2 = 8'hF0;

   // Storage slot of each register inside the bank.
   localparam logic [2:0] IDX_GPIO = 3'h0;
   localparam logic [2:0] IDX_VIN = 3'h1;
   localparam logic [2:0] IDX_TORCH = 3'h2;
   localparam logic [2:0] IDX_FLASH = 3'h3;
   localparam logic [2:0] IDX_DUR = 3'h4;
   localparam logic [2:0] IDX_FLAGS = 3'h5;
   localparam logic [2:0] IDX_CFG1 = 3'h6;
   localparam logic [2:0] IDX_CFG2 = 3'h7;

   // Values after reset, slot seven first.
   localparam logic [7:0][7:0] REGS_RESET = {
      8'hF0, 8'h42, 8'h40, 8'h4F, 8'h68, 8'h50, 8'hF0, 8'h80};

   // Field positions in the brightness registers.
   localparam int LED_FUNCTION_SEL_LO_BIT = 0;
   localparam int LED_FUNCTION_SEL_HI_BIT = 1;
   localparam int VOLTAGE_OUTPUT_ENABLE_BIT = 2;
   localparam int TORCH_CURRENT_SEL_B0_BIT = 3;
   localparam int TORCH_CURRENT_SEL_B2_BIT = 5;
   localparam int INDICATOR_CURRENT_SEL_LO_BIT = 6;
   localparam int INDICATOR_CURRENT_SEL_HI_BIT = 7;
   // Light-load disable bit in the first configuration register.
   localparam int LIGHT_LOAD_DISABLE_BIT = 0;

   // Serial port states, Gray coded along the usual path.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ACK_ADDR = 4'h3,
      ST_REG_ADDR = 4'h2,
      ST_ACK_REG = 4'h6,
      ST_WDATA = 4'h7,
      ST_ACK_DATA = 4'h5,
      ST_RDATA = 4'h4,
      ST_RACK = 4'hC,
      ST_IGNORE = 4'hD
   } ldc_state_t;

endpackage

// *** ldc_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin.
module ldc_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic din,
   output logic filt
);

   // Stage flops and the last agreed level.
   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic held;
   } ldc_sync_t;

   ldc_sync_t q;
   ldc_sync_t next_q;

   // The filtered level follows only when stages two and three agree.
   // Taking it combinationally from flops saves one cycle of latency.
   always_comb begin
      next_q = q;
      next_q.ff1 = din;
      next_q.ff2 = q.ff1;
      next_q.ff3 = q.ff2;
      if (q.ff2 == q.ff3) begin
         next_q.held = q.ff3;
      end
      filt = (q.ff2 == q.ff3) ? q.ff3 : q.held;
   end

   // Register all stages; reset loads the idle level.
   always_ff @(posedge mclk) begin
      if (reset) begin
         q <= {INIT, INIT, INIT, INIT};
      end else begin
         q <= next_q;
      end
   end

endmodule

// *** ldc_control_port.sv ***
// Serial control port and register bank of the LED driver.
module ldc_control_port (
   input wire logic mclk,
   input wire logic reset,
   // Serial clock from the master.
   input wire logic scl,
   // Serial data pin: level in, level out and drive enable.
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Light-load comparator result from the converter.
   input wire logic light_load_detect,
   // One-cycle pulse from the flash timer, same clock.
   input wire logic flash_timeout_done,
   // Bus occupied between start and stop.
   output logic bus_busy,
   // Converter runs in pulsed mode.
   output logic pulsed_mode,
   // Register contents for the analogue side.
   output logic [7:0] gpio_control,
   output logic [7:0] input_voltage_monitor,
   output logic [7:0] torch_brightness,
   output logic [7:0] flash_brightness,
   output logic [7:0] flash_duration,
   output logic [7:0] fault_flags,
   output logic [7:0] config_one,
   output logic [7:0] config_two,
   // Decoded enable field bits.
   output logic led_function_sel_lo,
   output logic led_function_sel_hi,
   output logic voltage_output_enable
);

   // Whole state of the port in one record.
   typedef struct packed {
      ldc_pkg::ldc_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic nack;
      logic scl_q;
      logic sda_q;
      logic oe;
      logic drv;
      logic busy;
      logic pulsed;
      logic [7:0][7:0] regs;
   } ldc_ctrl_t;

   ldc_ctrl_t q;
   ldc_ctrl_t next_q;

   // Filtered pin levels.
   logic scl_f;
   logic sda_f;
   logic light_f;

   // Map a register offset to its slot; bit three flags a hit.
   function automatic logic [3:0] reg_lookup(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a == ldc_pkg::OFS_GPIO) begin
         r = {1'b1, ldc_pkg::IDX_GPIO};
      end else if (a == ldc_pkg::OFS_VIN) begin
         r = {1'b1, ldc_pkg::IDX_VIN};
      end else if (a == ldc_pkg::OFS_TORCH) begin
         r = {1'b1, ldc_pkg::IDX_TORCH};
      end else if (a == ldc_pkg::OFS_FLASH) begin
         r = {1'b1, ldc_pkg::IDX_FLASH};
      end else if (a == ldc_pkg::OFS_DUR) begin
         r = {1'b1, ldc_pkg::IDX_DUR};
      end else if (a == ldc_pkg::OFS_FLAGS) begin
         r = {1'b1, ldc_pkg::IDX_FLAGS};
      end else if (a == ldc_pkg::OFS_CFG1) begin
         r = {1'b1, ldc_pkg::IDX_CFG1};
      end else if (a == ldc_pkg::OFS_CFG2) begin
         r = {1'b1, ldc_pkg::IDX_CFG2};
      end
      return r;
   endfunction

   // Byte that a read returns; unmapped offsets give zero.
   function automatic logic [7:0] read_byte(
      input logic [7:0][7:0] regs,
      input logic [7:0] a
   );
      logic [3:0] hit;
      logic [7:0] d;
      hit = reg_lookup(a);
      d = 8'h00;
      if (hit[3]) begin
         d = regs[hit[2:0]];
      end
      return d;
   endfunction

   // Both bus lines pass the same filter so their edges stay in order.
   ldc_sync #(.INIT(1'b1)) u_scl_sync (
      .mclk(mclk),
      .reset(reset),
      .din(scl),
      .filt(scl_f)
   );

   ldc_sync #(.INIT(1'b1)) u_sda_sync (
      .mclk(mclk),
      .reset(reset),
      .din(sda_in),
      .filt(sda_f)
   );

   // The comparator is analogue and asynchronous to this clock.
   ldc_sync #(.INIT(1'b0)) u_light_sync (
      .mclk(mclk),
      .reset(reset),
      .din(light_load_detect),
      .filt(light_f)
   );

   // Next-state logic for the port, the bank and the mode outputs.
   always_comb begin
      logic start_c;
      logic stop_c;
      logic rise_c;
      logic fall_c;
      logic [3:0] hit;
      logic [7:0] rd;
      start_c = 1'b0;
      stop_c = 1'b0;
      rise_c = 1'b0;
      fall_c = 1'b0;
      hit = 4'h0;
      rd = 8'h00;
      next_q = q;
      next_q.scl_q = scl_f;
      next_q.sda_q = sda_f;

      // Start: data falls with the clock high on both samples.
      start_c = scl_f & q.scl_q & q.sda_q & ~sda_f;
      // Stop: data rises with the clock high on both samples.
      stop_c = scl_f & q.scl_q & ~q.sda_q & sda_f;
      rise_c = scl_f & ~q.scl_q;
      fall_c = ~scl_f & q.scl_q;

      // A finished flash drops the flash bits in both copies.
      // Codes 011 and 111 become 000 and 100.
      // A serial write later in this process overrides the clear.
      if (flash_timeout_done &&
          q.regs[ldc_pkg::IDX_TORCH][1:0] == 2'b11) begin
         next_q.regs[ldc_pkg::IDX_TORCH][1:0] = 2'b00;
         next_q.regs[ldc_pkg::IDX_FLASH][1:0] = 2'b00;
      end

      // Pulsed mode needs the comparator enabled, voltage output on
      // and a light load; the LED function bits are not looked at.
      next_q.pulsed = light_f &
         ~q.regs[ldc_pkg::IDX_CFG1][ldc_pkg::LIGHT_LOAD_DISABLE_BIT] &
         q.regs[ldc_pkg::IDX_TORCH][ldc_pkg::VOLTAGE_OUTPUT_ENABLE_BIT];
      // The comparator level is filtered, so a glitch shorter than one
      // cycle never toggles the converter mode.

      if (start_c) begin
         // Start and repeated start restart address reception, so a
         // frame cut short by a new start never leaves stale bits.
         next_q.st = ldc_pkg::ST_ADDR;
         next_q.bitcnt = 4'h0;
         next_q.busy = 1'b1;
         next_q.oe = 1'b0;
         next_q.nack = 1'b0;
      end else if (stop_c) begin
         // Stop frees the bus and drops any drive.
         next_q.st = ldc_pkg::ST_IDLE;
         next_q.busy = 1'b0;
         next_q.oe = 1'b0;
      end else if (rise_c) begin
         // Data is sampled while the clock is high.
         case (q.st)
            ldc_pkg::ST_ADDR, ldc_pkg::ST_REG_ADDR,
            ldc_pkg::ST_WDATA: begin
               // Shift in at the bottom, MSB arrives first.
               next_q.shreg = {q.shreg[6:0], sda_f};
               next_q.bitcnt = q.bitcnt + 4'h1;
            end
            ldc_pkg::ST_RACK: begin
               // A high level here means the master refuses more.
               next_q.nack = sda_f;
            end
            default: begin
               next_q.nack = q.nack;
            end
         endcase
      end else if (fall_c) begin
         // All drive changes happen just after the clock falls, which
         // leaves the master about two cycles of margin before it rises.
         case (q.st)
            ldc_pkg::ST_ADDR: begin
               if (q.bitcnt == ldc_pkg::BYTE_BITS) begin
                  if (q.shreg[7:1] == ldc_pkg::DEV_ADDR) begin
                     next_q.rw = q.shreg[0];
                     next_q.oe = 1'b1;
                     next_q.st = ldc_pkg::ST_ACK_ADDR;
                  end else begin
                     // Foreign address: stay off the line.
                     next_q.st = ldc_pkg::ST_IGNORE;
                  end
               end
            end
            ldc_pkg::ST_ACK_ADDR: begin
               if (q.rw) begin
                  // Read: present the addressed register.
                  rd = read_byte(q.regs, q.ptr);
                  next_q.shreg = rd;
                  next_q.oe = ~rd[7];
                  next_q.bitcnt = 4'h1;
                  next_q.st = ldc_pkg::ST_RDATA;
               end else begin
                  next_q.oe = 1'b0;
                  next_q.bitcnt = 4'h0;
                  next_q.st = ldc_pkg::ST_REG_ADDR;
               end
            end
            ldc_pkg::ST_REG_ADDR: begin
               // First byte after the address picks the register.
               if (q.bitcnt == ldc_pkg::BYTE_BITS) begin
                  next_q.ptr = q.shreg;
                  next_q.oe = 1'b1;
                  next_q.st = ldc_pkg::ST_ACK_REG;
               end
            end
            ldc_pkg::ST_ACK_REG, ldc_pkg::ST_ACK_DATA: begin
               // Ninth pulse over; release and take the next byte.
               next_q.oe = 1'b0;
               next_q.bitcnt = 4'h0;
               next_q.st = ldc_pkg::ST_WDATA;
            end
            ldc_pkg::ST_WDATA: begin
               if (q.bitcnt == ldc_pkg::BYTE_BITS) begin
                  hit = reg_lookup(q.ptr);
                  // Flags are cleared by reading only, never written.
                  if (hit[3] && hit[2:0] != ldc_pkg::IDX_FLAGS) begin
                     next_q.regs[hit[2:0]] = q.shreg;
                  end
                  // The enable field lives in both brightness copies.
                  if (hit == {1'b1, ldc_pkg::IDX_TORCH}) begin
                     next_q.regs[ldc_pkg::IDX_FLASH][2:0] =
                        q.shreg[2:0];
                  end else if (hit == {1'b1, ldc_pkg::IDX_FLASH}) begin
                     next_q.regs[ldc_pkg::IDX_TORCH][2:0] =
                        q.shreg[2:0];
                  end
                  next_q.oe = 1'b1;
                  next_q.st = ldc_pkg::ST_ACK_DATA;
               end
            end
            ldc_pkg::ST_RDATA: begin
               if (q.bitcnt == ldc_pkg::BYTE_BITS) begin
                  // Byte done: hand the line to the master's answer.
                  next_q.oe = 1'b0;
                  next_q.nack = 1'b0;
                  next_q.st = ldc_pkg::ST_RACK;
                  // A completed read of the flags clears them; a read cut
                  // short by a start or stop leaves them standing.
                  if (reg_lookup(q.ptr) ==
                      {1'b1, ldc_pkg::IDX_FLAGS}) begin
                     next_q.regs[ldc_pkg::IDX_FLAGS] = 8'h00;
                  end
               end else begin
                  // Pulling low for a zero, releasing for a one.
                  next_q.shreg = {q.shreg[6:0], 1'b0};
                  next_q.oe = ~q.shreg[6];
                  next_q.bitcnt = q.bitcnt + 4'h1;
               end
            end
            ldc_pkg::ST_RACK: begin
               if (q.nack) begin
                  // Master is done; wait for its stop or start.
                  next_q.oe = 1'b0;
                  next_q.st = ldc_pkg::ST_IGNORE;
               end else begin
                  // Further bytes repeat the same register.
                  // There is no auto increment, so a burst re-reads one slot.
                  rd = read_byte(q.regs, q.ptr);
                  next_q.shreg = rd;
                  next_q.oe = ~rd[7];
                  next_q.bitcnt = 4'h1;
                  next_q.st = ldc_pkg::ST_RDATA;
               end
            end
            default: begin
               // Idle or ignoring: the line stays released.
               next_q.oe = 1'b0;
            end
         endcase
      end
   end

   // One register stage for all state; reset loads documented values.
   always_ff @(posedge mclk) begin
      if (reset) begin
         q.st <= ldc_pkg::ST_IDLE;
         q.bitcnt <= 4'h0;
         q.shreg <= 8'h00;
         q.ptr <= 8'h00;
         q.rw <= 1'b0;
         q.nack <= 1'b0;
         q.scl_q <= 1'b1;
         q.sda_q <= 1'b1;
         q.oe <= 1'b0;
         q.drv <= 1'b0;
         q.busy <= 1'b0;
         q.pulsed <= 1'b0;
         q.regs <= ldc_pkg::REGS_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Open-drain data: the only level ever driven is low.
   // The enable alone decides the wire, so it never drives high.
   assign sda_out = q.drv;
   assign sda_oe = q.oe;
   assign bus_busy = q.busy;
   assign pulsed_mode = q.pulsed;

   // The analogue side reads the bank directly.
   assign gpio_control = q.regs[ldc_pkg::IDX_GPIO];
   assign input_voltage_monitor = q.regs[ldc_pkg::IDX_VIN];
   assign torch_brightness = q.regs[ldc_pkg::IDX_TORCH];
   assign flash_brightness = q.regs[ldc_pkg::IDX_FLASH];
   assign flash_duration = q.regs[ldc_pkg::IDX_DUR];
   assign fault_flags = q.regs[ldc_pkg::IDX_FLAGS];
   assign config_one = q.regs[ldc_pkg::IDX_CFG1];
   assign config_two = q.regs[ldc_pkg::IDX_CFG2];

   // Operating mode comes from the shared enable field.
   assign led_function_sel_lo =
      q.regs[ldc_pkg::IDX_TORCH][ldc_pkg::LED_FUNCTION_SEL_LO_BIT];
   assign led_function_sel_hi =
      q.regs[ldc_pkg::IDX_TORCH][ldc_pkg::LED_FUNCTION_SEL_HI_BIT];
   assign voltage_output_enable =
      q.regs[ldc_pkg::IDX_TORCH][ldc_pkg::VOLTAGE_OUTPUT_ENABLE_BIT];

endmodule

// *** ldc_chk.sv ***
// Concurrent checks on the control port, seen only from its pins.
module ldc_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic flash_timeout_done,
   input wire logic bus_busy,
   input wire logic pulsed_mode,
   input wire logic [7:0] torch_brightness,
   input wire logic [7:0] flash_brightness,
   input wire logic [7:0] config_one,
   input wire logic led_function_sel_lo,
   input wire logic led_function_sel_hi,
   input wire logic voltage_output_enable
);
   // Everything runs on the system clock and rests during reset.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   // A start is SDA falling while SCL stays high.
   sequence s_start;
      scl && $past(scl) && $fell(sda_in);
   endsequence
   // A stop is SDA rising while SCL stays high.
   sequence s_stop;
      scl && $past(scl) && $rose(sda_in);
   endsequence

   a_reset_values:
   assert property ($fell(reset) |-> !bus_busy && !sda_oe &&
      torch_brightness == 8'h50 && flash_brightness == 8'h68 &&
      config_one == 8'h42)
      else $error("pin or register not at its reset value");
   a_busy_start:
   assert property (s_start |-> ##[1:8] bus_busy)
      else $error("bus not busy after start");
   a_busy_stop:
   assert property (s_stop |-> ##[1:8] !bus_busy)
      else $error("bus still busy after stop");
   // The synchronisers delay SCL, so a late change would hit the high.
   a_oe_scl_low:
   assert property ($changed(sda_oe) |-> !scl)
      else $error("data drive changed while clock high");
   a_oe_stable_high:
   assert property ($rose(scl) |-> ##1 $stable(sda_oe) [*4])
      else $error("data drive not held over clock high");
   a_mirror_equal:
   assert property (torch_brightness[2:0] == flash_brightness[2:0])
      else $error("enable copies differ");
   a_decode_bits:
   assert property ({voltage_output_enable, led_function_sel_hi,
      led_function_sel_lo} == torch_brightness[2:0])
      else $error("decoded enable bits wrong");
   a_timeout_clear:
   assert property (flash_timeout_done && !bus_busy &&
      torch_brightness[1:0] == 2'h3 |-> ##[1:2]
      (torch_brightness[1:0] == 2'h0 && flash_brightness[1:0] == 2'h0))
      else $error("flash code not cleared at timeout");
   a_timeout_keep:
   assert property (flash_timeout_done && !bus_busy &&
      torch_brightness[1:0] != 2'h3 |=> $stable(torch_brightness))
      else $error("timeout changed a non-flash code");
   a_pulsed_cause:
   assert property (pulsed_mode |->
      !$past(config_one[0]) && $past(torch_brightness[2]))
      else $error("pulsed mode without its conditions");
endmodule

bind ldc_control_port ldc_chk chk_u (.mclk(mclk), .reset(reset),
   .scl(scl), .sda_in(sda_in), .sda_oe(sda_oe),
   .flash_timeout_done(flash_timeout_done), .bus_busy(bus_busy),
   .pulsed_mode(pulsed_mode), .torch_brightness(torch_brightness),
   .flash_brightness(flash_brightness), .config_one(config_one),
   .led_function_sel_lo(led_function_sel_lo),
   .led_function_sel_hi(led_function_sel_hi),
   .voltage_output_enable(voltage_output_enable));

// *** ldc_mst.sv ***
// Behavioural serial bus master that drives the port's far side.
module ldc_mst (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus idles released; SCL stands high between frames.
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end
   // Waits whole cycles, then steps just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Start, or repeated start from a low clock.
   task automatic start();
      tick(2);
      sda_low = 1'h0;
      tick(4);
      scl = 1'h1;
      tick(2);
      sda_low = 1'h1;
      tick(2);
      scl = 1'h0;
   endtask
   // Stop, after which both lines are left released.
   task automatic stop();
      tick(2);
      sda_low = 1'h1;
      tick(4);
      scl = 1'h1;
      tick(2);
      sda_low = 1'h0;
      tick(4);
   endtask
   // Nine clocks, MSB first; a 1 releases SDA. The clock stays low for
   // six cycles because the device answers up to four cycles late.
   task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         tick(2);
         sda_low = !tx[i];
         tick(4);
         scl = 1'h1;
         tick(1);
         rx[i] = sda;
         tick(1);
         scl = 1'h0;
      end
   endtask
endmodule

// *** i2c_led_driver_control_port_test.sv ***
// Self-checking bench for the LED driver control port.
module i2c_led_driver_control_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   // Clock, reset and the converter-side inputs.
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic ll = 1'h0;
   logic tdone = 1'h0;
   // Bus pins and single-bit outputs of the device.
   logic scl, sda_low, sda_out, sda_oe, busy, pulsed, lo, hi, vm;
   // Register outputs in bank order, and the bench's own model.
   logic [7:0] rp [8];
   logic [7:0] mdl [8];
   logic [7:0] ofs [8] = '{8'h20, 8'h80, 8'hA0, 8'hB0, 8'hC0, 8'hD0,
      8'hE0, 8'hF0};
   logic [7:0] rst_v [8] = '{8'h80, 8'hF0, 8'h50, 8'h68, 8'h4F, 8'h40,
      8'h42, 8'hF0};
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   // SDA has a pull-up: high unless some party pulls it low.
   wire sda = !(sda_oe && !sda_out) && !sda_low;

   // The 10 MHz system clock.
   always #50 mclk = !mclk;

   ldc_control_port dut_u (.mclk(mclk), .reset(reset), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .light_load_detect(ll), .flash_timeout_done(tdone),
      .bus_busy(busy), .pulsed_mode(pulsed), .gpio_control(rp[0]),
      .input_voltage_monitor(rp[1]), .torch_brightness(rp[2]),
      .flash_brightness(rp[3]), .flash_duration(rp[4]),
      .fault_flags(rp[5]), .config_one(rp[6]), .config_two(rp[7]),
      .led_function_sel_lo(lo), .led_function_sel_hi(hi),
      .voltage_output_enable(vm));
   ldc_mst m_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

   // Prints the verdict and ends the run.
   task automatic results();
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compares one byte-wide result.
   task automatic chk(input string n, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Write frame; a foreign address must be refused on every byte.
   task automatic wr(input logic [6:0] a, input logic [7:0] o, d);
      logic [8:0] rx;
      logic [7:0] b [3];
      b = '{{a, 1'h0}, o, d};
      m_u.start();
      foreach (b[i]) begin
         m_u.bits9({b[i], 1'h1}, rx);
         chk("ack", {7'h0, a != 7'h53}, {7'h0, rx[0]});
      end
      m_u.stop();
      for (int i = 0; i < 8; i++)
         if (a == 7'h53 && ofs[i] == o && i != 5)
            mdl[i] = d;
      if (a == 7'h53 && o inside {8'hA0, 8'hB0}) begin
         mdl[2][2:0] = d[2:0];
         mdl[3][2:0] = d[2:0];
      end
   endtask
   // Read frame through a repeated start, ended by a refusal.
   task automatic rd(input logic [7:0] o);
      logic [8:0] rx;
      logic [7:0] e;
      e = 8'h0;
      for (int i = 0; i < 8; i++)
         if (ofs[i] == o)
            e = mdl[i];
      m_u.start();
      m_u.bits9({7'h53, 2'h1}, rx);
      m_u.bits9({o, 1'h1}, rx);
      m_u.start();
      m_u.bits9({7'h53, 2'h3}, rx);
      // The master acknowledges once, so the same register comes again.
      m_u.bits9(9'h1FE, rx);
      chk("rdata", e, rx[8:1]);
      if (o == 8'hD0)
         e = 8'h0;
      m_u.bits9(9'h1FF, rx);
      m_u.stop();
      chk("rdata_again", e, rx[8:1]);
      if (o == 8'hD0)
         mdl[5] = 8'h0;
   endtask
   // Lets the stop settle, then checks every output except pulsed against the model.
   task automatic ports();
      m_u.tick(4);
      for (int i = 0; i < 8; i++)
         chk($sformatf("reg%0d", i), mdl[i], rp[i]);
      chk("enable", {5'h0, mdl[2][2:0]}, {5'h0, vm, hi, lo});
      chk("busy", 8'h0, {7'h0, busy});
      chk("sda_oe", 8'h0, {7'h0, sda_oe});
      chk("sda_out", 8'h0, {7'h0, sda_out});
   endtask

   // Cuts a hang short; the run needs about 12200 cycles.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         results();
      end
   end

   // Main sequence.
   initial begin
      logic [7:0] d;
      d = 8'($urandom(32'hAC93));
      mdl = rst_v;
      repeat (10) @(posedge mclk);
      #1 reset = 1'h0;
      m_u.tick(5);
      ports();
      // Each register written with random data, then read back.
      for (int i = 0; i < 8; i++) begin
         wr(7'h53, ofs[i], 8'($urandom));
         rd(ofs[i]);
         ports();
      end
      // The read above cleared the flags, so they now read zero.
      rd(8'hD0);
      // An unmapped offset and a foreign address change nothing.
      wr(7'h53, 8'h30, 8'hFF);
      rd(8'h30);
      wr(7'h52, 8'hA0, 8'h07);
      ports();
      // Every enable code, each followed by a timeout pulse.
      for (int c = 0; c < 8; c++) begin
         wr(7'h53, 8'hB0, {5'($urandom), 3'(c)});
         m_u.tick(4);
         tdone = 1'h1;
         m_u.tick(1);
         tdone = 1'h0;
         if (mdl[2][1:0] == 2'h3) begin
            mdl[2][1:0] = 2'h0;
            mdl[3][1:0] = 2'h0;
         end
         ports();
      end
      // Pulsed mode needs light load, an enabled comparator and VM.
      for (int k = 0; k < 8; k++) begin
         wr(7'h53, 8'hE0, {7'($urandom), k[1]});
         wr(7'h53, 8'hA0, {5'($urandom), k[0], 2'h0});
         ll = k[2];
         m_u.tick(8);
         d = {7'h0, k[2] & !k[1] & k[0]};
         chk("pulsed", d, {7'h0, pulsed});
      end
      results();
   end
endmodule
